// ===== logic/scx_top.sv
// What this block does
// - Shift serial data on serial clock rise
// - Load strobe rise copies word to latch
// - Chip enable low clears all latches
// - Bit clock only in Gaussian modes
// - Sample data on bit clock rise
// - Dedicated transmit data input
// - Status output selects lock, ready, monitor
// - Reference clock out has equal halves
// - Even reference division two to thirty
// - Reference division sixteen after power-up
`timescale 1ns/1ns
module scx_top (
    input  wire logic CORE_CLK,
    input  wire logic SRST,
    input  wire logic SER_CLK,
    input  wire logic SER_DATA,
    input  wire logic LOAD_STROBE,
    input  wire logic CHIP_EN,
    input  wire logic TX_BIT_IN,
    input  wire logic PLL_LOCK,
    input  wire logic REG_READY,
    input  wire logic VOLT_OK,
    input  wire logic MOD_READY,
    output logic      TX_BIT_CLOCK,
    output logic      TX_BIT_DATA,
    output logic      TX_BIT_VALID,
    output logic      STATUS_MUX_OUT,
    output logic      REF_CLOCK_OUT,
    output logic      POWERED
);
    import scx_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync_prev;
    logic [SYNC_W-1:0] pins;

    assign pins = {VOLT_OK, REG_READY, PLL_LOCK, TX_BIT_IN,
                   CHIP_EN, LOAD_STROBE, SER_DATA, SER_CLK};

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync_prev <= '0;
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    logic enabled;
    logic sclk_rise;
    logic load_rise;
    assign enabled = sync2[S_CE];
    assign sclk_rise = sync2[S_SCLK] && !sync_prev[S_SCLK];
    assign load_rise = sync2[S_LOAD] && !sync_prev[S_LOAD];

    ////////////////////////////////////////////////////////////////////////
    // Shift register and configuration latches
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] latch [LATCH_N];
    logic [LATCH_N-1:0] loaded;
    logic [WORD_W-1:0] next_shift;
    logic [WORD_W-1:0] next_latch [LATCH_N];
    logic [LATCH_N-1:0] next_loaded;

    always_comb
    begin
        next_shift = shift;
        next_latch = latch;
        next_loaded = loaded;
        if (!enabled)
        begin
            next_shift = '0;
            next_loaded = '0;
            for (int i = 0; i < LATCH_N; i++)
                next_latch[i] = '0;
        end
        else
        begin
            if (sclk_rise)
                next_shift = {shift[WORD_W-2:0], sync2[S_SDATA]};
            if (load_rise)
            begin
                next_latch[shift[CTRL_W-1:0]] = shift;
                next_loaded[shift[CTRL_W-1:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            shift <= '0;
            loaded <= '0;
            for (int i = 0; i < LATCH_N; i++)
                latch[i] <= '0;
        end
        else
        begin
            shift <= next_shift;
            latch <= next_latch;
            loaded <= next_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings
    function automatic logic [RATE_W-1:0] at_least(input logic [RATE_W-1:0] v,
                                                   input logic [RATE_W-1:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    logic [RDIV_W-1:0] rdiv_half;
    logic              clk_out_en;
    scx_mux_type       mux_sel;
    scx_mode_type      mode;
    logic [RATE_W-1:0] rate_half;
    logic              gaussian;

    assign rdiv_half = !loaded[L_REF] ? RDIV_DEFAULT
        : RDIV_W'(at_least(RATE_W'(latch[L_REF][RDIV_LSB +: RDIV_W]),
                           RATE_W'(RDIV_MIN)));
    assign clk_out_en = !loaded[L_FUNC] || latch[L_FUNC][CLKEN_BIT];
    assign mux_sel = scx_mux_type'(latch[L_FUNC][MUX_LSB +: MUX_W]);
    assign mode = scx_mode_type'(latch[L_MOD][MODE_LSB +: MODE_W]);
    assign rate_half = at_least(latch[L_MOD][RATE_LSB +: RATE_W], RATE_MIN);
    assign gaussian = (mode == MODE_GFSK) || (mode == MODE_GOOK);

    ////////////////////////////////////////////////////////////////////////
    // Reference clock divider and status output
    logic [RDIV_W-1:0] ref_cnt;
    logic              ref_phase;
    logic [RDIV_W-1:0] next_ref_cnt;
    logic              next_ref_phase;
    logic              next_status;
    logic              next_ref_out;

    always_comb
    begin
        next_ref_cnt = RDIV_W'(ref_cnt + 1'b1);
        next_ref_phase = ref_phase;
        if (ref_cnt >= RDIV_W'(rdiv_half - 1'b1))
        begin
            next_ref_cnt = '0;
            next_ref_phase = !ref_phase;
        end
        case (mux_sel)
            MUX_LOCK:   next_status = sync2[S_LOCK];
            MUX_REGRDY: next_status = sync2[S_REGRDY];
            MUX_VMON:   next_status = sync2[S_VMON];
            default:    next_status = 1'b0;
        endcase
        if (!enabled)
        begin
            next_ref_cnt = '0;
            next_ref_phase = 1'b0;
            next_status = 1'b0;
        end
        next_ref_out = next_ref_phase && clk_out_en;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            ref_cnt <= '0;
            ref_phase <= 1'b0;
            STATUS_MUX_OUT <= 1'b0;
            REF_CLOCK_OUT <= 1'b0;
        end
        else
        begin
            ref_cnt <= next_ref_cnt;
            ref_phase <= next_ref_phase;
            STATUS_MUX_OUT <= next_status;
            REF_CLOCK_OUT <= next_ref_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit bit clock and sampling into the FIFO
    typedef enum logic {TX_LOW, TX_HIGH} scx_tx_type;

    scx_tx_type        tx_state;
    logic [RATE_W-1:0] tx_cnt;
    logic              bit_clk;
    logic              push_valid;
    logic              push_bit;
    scx_tx_type        next_tx_state;
    logic [RATE_W-1:0] next_tx_cnt;
    logic              next_bit_clk;
    logic              next_push_valid;
    logic              next_push_bit;

    scx_stream_if in_s ();
    scx_stream_if out_s ();

    assign in_s.valid = push_valid;
    assign in_s.data = push_bit;
    assign out_s.ready = MOD_READY;

    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_cnt = RATE_W'(tx_cnt + 1'b1);
        next_bit_clk = bit_clk;
        next_push_valid = push_valid && !in_s.ready;
        next_push_bit = push_bit;
        case (tx_state)
            TX_LOW:
            begin
                // Stall before the rising edge while a sample is pending
                if (push_valid)
                    next_tx_cnt = tx_cnt;
                else if (tx_cnt >= RATE_W'(rate_half - 1'b1))
                begin
                    next_tx_cnt = '0;
                    next_tx_state = TX_HIGH;
                    next_bit_clk = gaussian;
                    next_push_valid = 1'b1;
                    next_push_bit = sync2[S_TXBIT];
                end
            end
            TX_HIGH:
            begin
                if (tx_cnt >= RATE_W'(rate_half - 1'b1))
                begin
                    next_tx_cnt = '0;
                    next_tx_state = TX_LOW;
                    next_bit_clk = 1'b0;
                end
            end
            default:
                next_tx_state = TX_LOW;
        endcase
        if (!enabled)
        begin
            next_tx_state = TX_LOW;
            next_tx_cnt = '0;
            next_bit_clk = 1'b0;
            next_push_valid = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            tx_state <= TX_LOW;
            tx_cnt <= '0;
            bit_clk <= 1'b0;
            push_valid <= 1'b0;
            push_bit <= 1'b0;
            POWERED <= 1'b0;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            bit_clk <= next_bit_clk;
            push_valid <= next_push_valid;
            push_bit <= next_push_bit;
            POWERED <= enabled;
        end
    end

    scx_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (CORE_CLK),
        .srst  (SRST || !enabled),
        .in_s  (in_s),
        .out_s (out_s)
    );

    assign TX_BIT_CLOCK = bit_clk;
    assign TX_BIT_DATA = out_s.data;
    assign TX_BIT_VALID = out_s.valid;
endmodule // scx_top

// ===== logic/scx_pkg.sv
package scx_pkg;
    localparam int          WORD_W       = 32;
    localparam int          LATCH_N      = 4;
    localparam int          CTRL_W       = 2;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          SYNC_W       = 8;
    // Synchroniser lane positions
    localparam int          S_SCLK       = 0;
    localparam int          S_SDATA      = 1;
    localparam int          S_LOAD       = 2;
    localparam int          S_CE         = 3;
    localparam int          S_TXBIT      = 4;
    localparam int          S_LOCK       = 5;
    localparam int          S_REGRDY     = 6;
    localparam int          S_VMON       = 7;
    // Latch indices
    localparam logic [1:0]  L_REF        = 2'h0;
    localparam logic [1:0]  L_MOD        = 2'h2;
    localparam logic [1:0]  L_FUNC       = 2'h3;
    // Reference divider field, half-ratio code
    localparam int          RDIV_LSB     = 19;
    localparam int          RDIV_W       = 4;
    localparam logic [3:0]  RDIV_DEFAULT = 4'h8;
    localparam logic [3:0]  RDIV_MIN     = 4'h1;
    // Function latch fields
    localparam int          CLKEN_BIT    = 4;
    localparam int          MUX_LSB      = 10;
    localparam int          MUX_W        = 2;
    // Modulation latch fields
    localparam int          MODE_LSB     = 2;
    localparam int          MODE_W       = 3;
    localparam int          RATE_LSB     = 20;
    localparam int          RATE_W       = 12;
    localparam logic [11:0] RATE_MIN     = 12'h001;

    typedef enum logic [2:0] {
        MODE_FSK, MODE_GFSK, MODE_ASK, MODE_OOK, MODE_GOOK
    } scx_mode_type;

    typedef enum logic [1:0] {
        MUX_LOCK, MUX_REGRDY, MUX_VMON, MUX_LOW
    } scx_mux_type;
endpackage

// ===== logic/scx_stream_if.sv
`timescale 1ns/1ns
interface scx_stream_if;
    logic valid;
    logic ready;
    logic data;
    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// ===== logic/scx_fifo.sv
`timescale 1ns/1ns
module scx_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic   clk,
    input  wire logic   srst,
    scx_stream_if.snk   in_s,
    scx_stream_if.src   out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_s.ready = (count != (AW+1)'(DEPTH));
    assign out_s.valid = out_valid;
    assign out_s.data = out_data;

    always_comb
    begin
        push = in_s.valid && in_s.ready;
        pop = (count != '0) && (!out_valid || out_s.ready);
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop)
            next_count = (AW+1)'(count + 1'b1);
        else if (pop && !push)
            next_count = (AW+1)'(count - 1'b1);
        next_out_valid = out_valid && !out_s.ready;
        next_out_data = out_data;
        if (pop)
        begin
            next_out_valid = 1'b1;
            next_out_data = mem[rd_ptr];
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_s.data;
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end
endmodule // scx_fifo

// ===== verif/scx_top_properties.sv
`timescale 1ns/1ns
module scx_top_properties (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic LOAD_STROBE,
    input wire logic CHIP_EN,
    input wire logic TX_BIT_IN,
    input wire logic PLL_LOCK,
    input wire logic REG_READY,
    input wire logic VOLT_OK,
    input wire logic MOD_READY,
    input wire logic TX_BIT_CLOCK,
    input wire logic TX_BIT_DATA,
    input wire logic TX_BIT_VALID,
    input wire logic STATUS_MUX_OUT,
    input wire logic REF_CLOCK_OUT,
    input wire logic POWERED
);
    // Cycles the divided clock has already been high
    logic [4:0] hi_run;
    always_ff @(posedge CORE_CLK)
    begin
        hi_run <= (SRST || !REF_CLOCK_OUT) ? 5'h00 : hi_run + 5'h01;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    reset_zero_a: assert property ($fell(SRST) |-> !TX_BIT_CLOCK && !TX_BIT_VALID
        && !STATUS_MUX_OUT && !REF_CLOCK_OUT && !POWERED) else $error("outputs not cleared");
    power_off_a: assert property ((!CHIP_EN) [*4] |=> !POWERED)
        else $error("still powered");
    power_on_a: assert property (CHIP_EN [*4] |=> POWERED)
        else $error("not powered");
    down_idle_a: assert property ((!POWERED) [*2] |->
        !TX_BIT_VALID && !TX_BIT_CLOCK && !REF_CLOCK_OUT) else $error("active in power-down");
    valid_hold_a: assert property (CHIP_EN [*3] ##0 (TX_BIT_VALID && !MOD_READY) |=>
        TX_BIT_VALID && $stable(TX_BIT_DATA)) else $error("output dropped");
    sample_push_a: assert property ($rose(TX_BIT_CLOCK) |-> ##[0:4] TX_BIT_VALID)
        else $error("sample not queued");
    ref_high_a: assert property (REF_CLOCK_OUT |-> hi_run < 5'h0F)
        else $error("divided clock high too long");
    wake_cause_a: assert property ($rose(TX_BIT_VALID) || $rose(REF_CLOCK_OUT) |-> POWERED)
        else $error("activity while off");
endmodule // scx_top_properties
bind scx_top scx_top_properties scx_top_properties_i (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
    .LOAD_STROBE(LOAD_STROBE), .CHIP_EN(CHIP_EN), .TX_BIT_IN(TX_BIT_IN),
    .PLL_LOCK(PLL_LOCK), .REG_READY(REG_READY), .VOLT_OK(VOLT_OK), .MOD_READY(MOD_READY),
    .TX_BIT_CLOCK(TX_BIT_CLOCK), .TX_BIT_DATA(TX_BIT_DATA), .TX_BIT_VALID(TX_BIT_VALID),
    .STATUS_MUX_OUT(STATUS_MUX_OUT), .REF_CLOCK_OUT(REF_CLOCK_OUT), .POWERED(POWERED));

// ===== verif/scx_host_model.sv
`timescale 1ns/1ns
module scx_host_model (
    input  wire logic core_clk,
    input  wire logic bit_clock,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      load_strobe,
    output logic      tx_bit_in
);
    logic last_clock = 1'b0;
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
        tx_bit_in = 1'b0;
    end
    task automatic write_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge core_clk);
            ser_clk <= 1'b0;
            ser_data <= w[i];
            repeat (2) @(posedge core_clk);
            ser_clk <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
        ser_clk <= 1'b0;
        repeat (2) @(posedge core_clk);
        load_strobe <= 1'b1;
        repeat (2) @(posedge core_clk);
        load_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    always @(posedge core_clk)
    begin
        last_clock <= bit_clock;
        if (last_clock && !bit_clock)
            tx_bit_in <= ~tx_bit_in;
    end
endmodule // scx_host_model

// ===== verif/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
    import scx_pkg::*;
    typedef struct packed { logic [1:0] mux; logic [2:0] src; logic exp; } scx_row_type;
    logic CORE_CLK, SRST, CHIP_EN, PLL_LOCK, REG_READY, VOLT_OK, MOD_READY;
    logic SER_CLK, SER_DATA, LOAD_STROBE, TX_BIT_IN;
    logic TX_BIT_CLOCK, TX_BIT_DATA, TX_BIT_VALID, STATUS_MUX_OUT, REF_CLOCK_OUT, POWERED;
    int   n_mismatch = 0;
    int   checks_done = 0;
    int   hi, lo, cnt, t;
    logic prev;
    scx_row_type rows [6] = '{'{2'h0, 3'h1, 1'b1}, '{2'h0, 3'h6, 1'b0}, '{2'h1, 3'h2, 1'b1},
                              '{2'h1, 3'h5, 1'b0}, '{2'h2, 3'h4, 1'b1}, '{2'h3, 3'h7, 1'b0}};
    scx_top scx_top_i (.CORE_CLK(CORE_CLK), .SRST(SRST), .SER_CLK(SER_CLK),
        .SER_DATA(SER_DATA), .LOAD_STROBE(LOAD_STROBE), .CHIP_EN(CHIP_EN),
        .TX_BIT_IN(TX_BIT_IN), .PLL_LOCK(PLL_LOCK), .REG_READY(REG_READY),
        .VOLT_OK(VOLT_OK), .MOD_READY(MOD_READY), .TX_BIT_CLOCK(TX_BIT_CLOCK),
        .TX_BIT_DATA(TX_BIT_DATA), .TX_BIT_VALID(TX_BIT_VALID),
        .STATUS_MUX_OUT(STATUS_MUX_OUT), .REF_CLOCK_OUT(REF_CLOCK_OUT), .POWERED(POWERED));
    scx_host_model scx_host_model_i (.core_clk(CORE_CLK), .bit_clock(TX_BIT_CLOCK),
        .ser_clk(SER_CLK), .ser_data(SER_DATA), .load_strobe(LOAD_STROBE),
        .tx_bit_in(TX_BIT_IN));
    task print_verdict;
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run_len(input bit sel, input logic lvl, output int n);
        n = 0;
        while (((sel ? TX_BIT_CLOCK : REF_CLOCK_OUT) === lvl) && n < 200)
        begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
    endtask
    task automatic meas_ref(input int k);
        int d;
        @(posedge CORE_CLK);
        #1;
        run_len(1'b0, 1'b1, d);
        run_len(1'b0, 1'b0, d);
        run_len(1'b0, 1'b1, hi);
        run_len(1'b0, 1'b0, lo);
        `CHK(hi, k)
        `CHK(lo, k)
    endtask
    task automatic count_bclk();
        cnt = 0;
        repeat (10) @(posedge CORE_CLK);
        repeat (60)
        begin
            @(posedge CORE_CLK);
            #1;
            cnt += (TX_BIT_CLOCK === 1'b1);
        end
    endtask
    task automatic mode_check(input logic [2:0] m);
        scx_host_model_i.write_word({12'h004, 15'h0000, m, 2'h2});
        count_bclk();
        `CHK(cnt != 0, m == MODE_GFSK || m == MODE_GOOK)
    endtask
    initial
    begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    initial
    begin
        repeat (30000) @(posedge CORE_CLK);
        n_mismatch++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        SRST = 1'b1;
        CHIP_EN = 1'b1;
        {VOLT_OK, REG_READY, PLL_LOCK} = 3'h0;
        MOD_READY = 1'b1;
        repeat (5) @(posedge CORE_CLK);
        SRST <= 1'b0;
        repeat (5) @(posedge CORE_CLK);
        meas_ref(8);
        foreach (rows[i])
        begin
            {VOLT_OK, REG_READY, PLL_LOCK} <= rows[i].src;
            scx_host_model_i.write_word({20'h0, rows[i].mux, 5'h00, 1'b1, 2'h0, 2'h3});
            repeat (5) @(posedge CORE_CLK);
            #1;
            `CHK(STATUS_MUX_OUT, rows[i].exp)
        end
        for (int i = 0; i < 2; i++)
        begin
            scx_host_model_i.write_word({9'h000, (i == 0) ? 4'h1 : 4'hF, 19'h0});
            meas_ref((i == 0) ? 1 : 15);
        end
        for (int m = 0; m < 5; m++)
            mode_check(m[2:0]);
        repeat (60) @(posedge CORE_CLK);
        MOD_READY <= 1'b0;
        repeat (120) @(posedge CORE_CLK);
        #1;
        `CHK({TX_BIT_CLOCK, TX_BIT_VALID}, 2'b01)
        MOD_READY <= 1'b1;
        for (int j = 0; j < 13; j++)
        begin
            @(negedge CORE_CLK);
            t = 0;
            while (TX_BIT_VALID !== 1'b1 && t < 100)
            begin
                @(negedge CORE_CLK);
                t++;
            end
            if (j > 0)
                `CHK(TX_BIT_DATA, ~prev)
            prev = TX_BIT_DATA;
        end
        // Power down clear of a bit clock rise
        @(negedge TX_BIT_CLOCK);
        @(posedge CORE_CLK);
        CHIP_EN <= 1'b0;
        repeat (10) @(posedge CORE_CLK);
        #1;
        `CHK({POWERED, TX_BIT_VALID, REF_CLOCK_OUT}, 3'h0)
        CHIP_EN <= 1'b1;
        repeat (10) @(posedge CORE_CLK);
        meas_ref(8);
        count_bclk();
        `CHK(cnt, 0)
        mode_check(MODE_GFSK);
        @(posedge CORE_CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        #1;
        `CHK({TX_BIT_CLOCK, TX_BIT_VALID, STATUS_MUX_OUT, REF_CLOCK_OUT, POWERED}, 5'h00)
        print_verdict;
    end
endmodule // testbench
